//--- inc/shm_regs.svh
`ifndef SHM_REGS_SVH
`define SHM_REGS_SVH

// Byte addresses inside the 2 KB shared window
`define SHM_MSW_ADDR      11'h000
`define SHM_MCW_ADDR      11'h004
`define SHM_MASTER_CONTROL_STATUS_BLOCK_LAST     11'h00f
`define SHM_MCE_ADDR      11'h010
`define SHM_CQE_BASE      11'h01c
`define SHM_COMMAND_BLOCK_LAST     11'h72f
`define SHM_CRB_ADDR      11'h730
`define SHM_RET_ADDR      11'h740
`define SHM_CFG_ADDR      11'h764
`define SHM_STAT_ADDR     11'h7ac
`define SHM_WIN_LAST      11'h7ff
`define SHM_ENTRY_BYTES   12'h00c
`define SHM_WORDS         1024

// Field positions
`define SHM_NA_BIT        0
`define SHM_BG_BIT        1
`define SHM_QS_BIT        0
`define SHM_RST_BIT       12
`define SHM_BUS_FAIL_ENABLE_BIT_BIT      13
`define SHM_GO_BIT        0

// Reset values
`define SHM_MCW_RESET     16'h0000

// Timing
`define SHM_CLK_MHZ       40
`define SHM_RST_HOLD_US   50
`define SHM_RST_CYCLES    (`SHM_RST_HOLD_US * `SHM_CLK_MHZ)
`define SHM_RST_CNT_W     12

`endif

//--- inc/shm_pkg.sv
package shm_pkg;

    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0001,
        ST_READ   = 4'b0010,
        ST_ACK    = 4'b0100,
        ST_IGNORE = 4'b1000
    } shm_state_type;

    typedef enum logic [2:0] {
        RG_MASTER_CONTROL_STATUS_BLOCK   = 3'h0,
        RG_MCE    = 3'h1,
        RG_QUEUE  = 3'h2,
        RG_COMMAND_BLOCK   = 3'h3,
        RG_RESP   = 3'h4,
        RG_RET    = 3'h5,
        RG_CFG    = 3'h6,
        RG_STAT   = 3'h7
    } shm_region_type;

endpackage

//--- src/shm_window_mem.sv
`timescale 1ns/1ps
`include "shm_regs.svh"

module shm_window_mem
    import shm_pkg::*;
(
    // Clock
    input  wire logic        mclk,
    // Single write port
    input  wire logic        wr_en,
    input  wire logic [9:0]  wr_idx,
    input  wire logic [15:0] wr_data,
    // Two registered read ports
    input  wire logic [9:0]  rd_idx_a,
    output logic      [15:0] rd_data_a,
    input  wire logic [9:0]  rd_idx_b,
    output logic      [15:0] rd_data_b
);
    logic [15:0] mem [`SHM_WORDS];

    genvar i;
    generate
        for (i = 0; i < `SHM_WORDS; i++) begin : g_word
            always_ff @(posedge mclk) begin
                if (wr_en && wr_idx == 10'(i)) begin
                    mem[i] <= wr_data;
                end
            end
        end
    endgenerate

    always_ff @(posedge mclk) begin
        rd_data_a <= mem[rd_idx_a];
        rd_data_b <= mem[rd_idx_b];
    end
endmodule // shm_window_mem

//--- src/shm_host_if.sv
// How it works
// - Control block at base, master entry at 0x010, queue entries from 0x01C up to the command blocks.
// - Response at 0x730, returned blocks 0x740, config 0x764, statistics at the top.
// - Each queue entry, master or general, is one 12-byte block.
// - Onboard command blocks sit between last entry and response block.
// - Configuration region may be overwritten with multiple-completion records.
// - Statistics written only with single-channel card, or by multiple-completion records.
// - Record offsets count 16-bit units from the record start.
// - Range end addresses are the last byte included.
// - Window answers only accesses in the secondary short I/O space.
// - Not-available flag is 1 whenever commands cannot be accepted, incl. reset.
// - Board-good flag set only after diagnostics pass and commands are accepted.
// - Control word changed only by host writes; cleared at power-up.
// - Queue-start bit raises a completion event, then queue-started flag stays set until the controller is reset.
// - Reset bit resets the controller; held at least 50 microseconds.
// - Bus-fail enable bit is stored and read back, with no effect.
// - Host go flag marks a posted entry; controller copies, then clears it.
`timescale 1ns/1ps
`include "shm_regs.svh"

module shm_host_if
    import shm_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // Host backplane side (asynchronous pins)
    input  wire logic        host_strobe,
    input  wire logic        host_secondary,
    input  wire logic        host_write,
    input  wire logic [10:0] host_addr,
    input  wire logic [15:0] host_wdata,
    output logic             host_ack,
    output logic      [15:0] host_rdata,
    // Controller firmware side (same clock)
    input  wire logic        ctl_wr,
    input  wire logic        ctl_multi,
    input  wire logic [9:0]  ctl_addr,
    input  wire logic [15:0] ctl_wdata,
    output logic      [15:0] ctl_rdata,
    output logic      [2:0]  ctl_region,
    output logic             ctl_reject,
    // Board state inputs
    input  wire logic        diag_pass,
    input  wire logic        fw_busy,
    input  wire logic        fw_ready,
    input  wire logic        single_chan_card,
    input  wire logic [7:0]  queue_len,
    // Controller events and status
    output logic             ctl_reset,
    output logic             qstart_evt,
    output logic             queue_started_flag,
    output logic             go_posted,
    output logic      [10:0] go_addr,
    output logic             not_available_flag,
    output logic             board_good_flag
);
    shm_state_type            st;
    shm_state_type            next_st;
    logic                     strb_s1;
    logic                     strb_s2;
    logic                     strb_s3;
    logic                     lat_wr;
    logic [10:0]              lat_addr;
    logic [15:0]              ctrl_word;
    logic                     post_reset;
    logic [`SHM_RST_CNT_W-1:0] hold_cnt;
    logic [15:0]              ram_rd_a;
    logic [15:0]              ram_rd_b;

    // The strobe pin passes three flops; a level counts once stages two and three agree
    always_ff @(posedge mclk) begin
        if (rst) begin
            strb_s1 <= 1'b0;
            strb_s2 <= 1'b0;
            strb_s3 <= 1'b0;
        end else begin
            strb_s1 <= host_strobe;
            strb_s2 <= strb_s1;
            strb_s3 <= strb_s2;
        end
    end

    wire strb_on  = strb_s2 & strb_s3;
    wire strb_off = ~strb_s2 & ~strb_s3;

    // Region decode on byte addresses; the two LAST bounds are the last byte included, the others are the next region's first byte
    function automatic shm_region_type region_of(input logic [10:0] a,
                                                 input logic [11:0] command_block_first);
        if (a <= `SHM_MASTER_CONTROL_STATUS_BLOCK_LAST)                   return RG_MASTER_CONTROL_STATUS_BLOCK;
        else if (a < `SHM_CQE_BASE)                return RG_MCE;
        else if ({1'b0, a} < command_block_first)           return RG_QUEUE;
        else if (a <= `SHM_COMMAND_BLOCK_LAST)              return RG_COMMAND_BLOCK;
        else if (a < `SHM_RET_ADDR)                return RG_RESP;
        else if (a < `SHM_CFG_ADDR)                return RG_RET;
        else if (a < `SHM_STAT_ADDR)               return RG_CFG;
        else                                       return RG_STAT;
    endfunction

    // Queue entries are 12-byte blocks after the master entry
    wire [11:0] queue_bytes = 12'(queue_len * `SHM_ENTRY_BYTES);
    wire [11:0] command_block_first  = {1'b0, `SHM_CQE_BASE} + queue_bytes;

    // Controller addresses count 16-bit units; byte address is twice the index
    wire [10:0]          ctl_byte   = {ctl_addr, 1'b0};
    wire shm_region_type ctl_rg     = region_of(ctl_byte, command_block_first);
    wire                 ctl_stat_ok = single_chan_card | ctl_multi;
    wire                 ctl_wr_ok  = ctl_wr && ctl_rg != RG_MASTER_CONTROL_STATUS_BLOCK &&
                                      (ctl_rg != RG_STAT || ctl_stat_ok);
    wire                 ctl_wr_bad = ctl_wr & ~ctl_wr_ok;

    // Host access is taken in idle; a colliding controller write goes first
    wire in_idle   = (st == ST_IDLE);
    wire take      = in_idle & strb_on & host_secondary &
                     ~(host_write & ctl_wr_ok);
    wire refuse    = in_idle & strb_on & ~host_secondary;
    wire hwr       = take & host_write;
    wire shm_region_type host_rg = region_of(host_addr, command_block_first);
    wire host_master_control_status_block = (host_rg == RG_MASTER_CONTROL_STATUS_BLOCK);
    wire mcw_wr    = hwr & ({host_addr[10:1], 1'b0} == `SHM_MCW_ADDR);
    wire ram_we    = ctl_wr_ok | (hwr & ~host_master_control_status_block);
    wire [9:0]  ram_idx  = ctl_wr_ok ? ctl_addr : host_addr[10:1];
    wire [15:0] ram_data = ctl_wr_ok ? ctl_wdata : host_wdata;

    // Go flag detection on the first word of the master entry or a queue entry
    wire [11:0] q_off   = {1'b0, host_addr} - {1'b0, `SHM_CQE_BASE};
    wire        q_start = (host_rg == RG_QUEUE) && (q_off % `SHM_ENTRY_BYTES == 12'h000);
    wire        m_start = ({host_addr[10:1], 1'b0} == `SHM_MCE_ADDR);
    wire        go_hit  = hwr & host_wdata[`SHM_GO_BIT] & (q_start | m_start);

    // Control word fields
    wire [15:0] mcw_mask = (16'h0001 << `SHM_QS_BIT) | (16'h0001 << `SHM_RST_BIT) |
                           (16'h0001 << `SHM_BUS_FAIL_ENABLE_BIT_BIT);
    wire        qs_rise  = mcw_wr & host_wdata[`SHM_QS_BIT] & ~ctrl_word[`SHM_QS_BIT];
    wire        rst_bit  = ctrl_word[`SHM_RST_BIT];
    wire        rst_rise = mcw_wr & host_wdata[`SHM_RST_BIT] & ~rst_bit;

    // Live status word, built from the registered flags
    wire [15:0] msw_val = (16'(not_available_flag) << `SHM_NA_BIT) |
                          (16'(board_good_flag) << `SHM_BG_BIT);
    wire        lat_msw = ({lat_addr[10:1], 1'b0} == `SHM_MSW_ADDR);
    wire        lat_mcw = ({lat_addr[10:1], 1'b0} == `SHM_MCW_ADDR);
    wire        lat_master_control_status_block = (lat_addr <= `SHM_MASTER_CONTROL_STATUS_BLOCK_LAST);
    wire [15:0] master_control_status_block_rd = lat_msw ? msw_val :
                          lat_mcw ? ctrl_word : 16'h0000;
    wire [15:0] next_rdata = lat_master_control_status_block ? master_control_status_block_rd : ram_rd_a;

    // Status flags; post_reset holds off availability until firmware reports ready
    wire next_na = ctl_reset | post_reset | fw_busy;
    wire next_bg = diag_pass & ~next_na;

    always_comb begin
        next_st = st;
        unique case (st)
            ST_IDLE: begin
                if (take) begin
                    next_st = ST_READ;
                end else if (refuse) begin
                    next_st = ST_IGNORE;
                end
            end
            ST_READ: begin
                next_st = ST_ACK;
            end
            ST_ACK, ST_IGNORE: begin
                if (strb_off) begin
                    next_st = ST_IDLE;
                end
            end
            default: begin
                next_st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st       <= ST_IDLE;
            host_ack <= 1'b0;
        end else begin
            st       <= next_st;
            host_ack <= (next_st == ST_ACK);
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            lat_wr     <= 1'b0;
            lat_addr   <= 11'h000;
            host_rdata <= 16'h0000;
        end else if (take) begin
            lat_wr   <= host_write;
            lat_addr <= host_addr;
        end else if (st == ST_READ && !lat_wr) begin
            host_rdata <= next_rdata;
        end
    end

    // Only a host write touches the control word; power-up clears it
    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrl_word <= `SHM_MCW_RESET;
        end else if (mcw_wr) begin
            ctrl_word <= host_wdata & mcw_mask;
        end
    end

    // Controller reset lasts while the bit is set and at least the hold time,
    // so an early clear by the host cannot cut the reset short
    always_ff @(posedge mclk) begin
        if (rst) begin
            hold_cnt  <= '0;
            ctl_reset <= 1'b0;
        end else begin
            if (rst_rise) begin
                hold_cnt <= `SHM_RST_CNT_W'(`SHM_RST_CYCLES);
            end else if (hold_cnt != '0) begin
                hold_cnt <= hold_cnt - `SHM_RST_CNT_W'(1);
            end
            ctl_reset <= rst_bit | rst_rise | (hold_cnt > `SHM_RST_CNT_W'(1));
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            post_reset         <= 1'b1;
            not_available_flag <= 1'b1;
            board_good_flag    <= 1'b0;
        end else begin
            if (ctl_reset) begin
                post_reset <= 1'b1;
            end else if (fw_ready) begin
                post_reset <= 1'b0;
            end
            not_available_flag <= next_na;
            board_good_flag    <= next_bg;
        end
    end

    // Queue-started flag survives until the controller is reset
    always_ff @(posedge mclk) begin
        if (rst) begin
            qstart_evt         <= 1'b0;
            queue_started_flag <= 1'b0;
        end else begin
            qstart_evt <= qs_rise;
            if (qs_rise) begin
                queue_started_flag <= 1'b1;
            end else if (ctl_reset) begin
                queue_started_flag <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            go_posted  <= 1'b0;
            go_addr    <= 11'h000;
            ctl_reject <= 1'b0;
            ctl_region <= 3'h0;
        end else begin
            go_posted  <= go_hit;
            ctl_reject <= ctl_wr_bad;
            ctl_region <= ctl_rg;
            if (go_hit) begin
                go_addr <= host_addr;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            ctl_rdata <= 16'h0000;
        end else begin
            ctl_rdata <= ram_rd_b;
        end
    end

    shm_window_mem u_mem (
        .mclk      (mclk),
        .wr_en     (ram_we),
        .wr_idx    (ram_idx),
        .wr_data   (ram_data),
        .rd_idx_a  (host_addr[10:1]),
        .rd_data_a (ram_rd_a),
        .rd_idx_b  (ctl_addr),
        .rd_data_b (ram_rd_b)
    );

    AST_NA_IN_RESET: assert property (@(posedge mclk) disable iff (rst)
        ctl_reset |=> not_available_flag)
        else $error("not-available flag low during controller reset");

    AST_BG_ONLY_AVAILABLE: assert property (@(posedge mclk) disable iff (rst)
        board_good_flag |-> !not_available_flag && $past(diag_pass))
        else $error("board-good set while unavailable or diagnostics failed");

    AST_MCW_HOST_ONLY: assert property (@(posedge mclk) disable iff (rst)
        $changed(ctrl_word) |-> $past(mcw_wr))
        else $error("control word changed without host write");

    AST_QSTART_FLAG: assert property (@(posedge mclk) disable iff (rst)
        qstart_evt |-> queue_started_flag ##1 !qstart_evt)
        else $error("queue start event not followed by started flag");

    AST_RESET_HOLD: assert property (@(posedge mclk) disable iff (rst)
        rst_rise |=> ctl_reset [*8] ##0 (hold_cnt > `SHM_RST_CNT_W'(`SHM_RST_CYCLES - 8)))
        else $error("controller reset shorter than hold time");

    AST_NO_ANSWER_OFF_SPACE: assert property (@(posedge mclk) disable iff (rst)
        refuse |=> (st == ST_IGNORE) && !host_ack)
        else $error("answered access outside secondary space");

    AST_STAT_GUARD: assert property (@(posedge mclk) disable iff (rst)
        (ctl_wr && ctl_rg == RG_STAT && !ctl_stat_ok) |=> ctl_reject)
        else $error("statistics write not refused");

    AST_RESERVED_ZERO: assert property (@(posedge mclk) disable iff (rst)
        (st == ST_READ && !lat_wr && lat_master_control_status_block && !lat_msw && !lat_mcw)
        |=> host_rdata == 16'h0000 && host_ack)
        else $error("reserved control block word read nonzero");

    AST_GO_PULSE: assert property (@(posedge mclk) disable iff (rst)
        go_hit |=> go_posted && go_addr == $past(host_addr) ##1 !go_posted || go_hit)
        else $error("go detection pulse wrong");
endmodule // shm_host_if

//--- verif/shm_host_bfm.sv
`timescale 1ns/1ps

module shm_host_bfm (
    // Clock
    input  wire logic        mclk,
    // Backplane master pins
    output logic             host_strobe,
    output logic             host_secondary,
    output logic             host_write,
    output logic      [10:0] host_addr,
    output logic      [15:0] host_wdata,
    input  wire logic        host_ack,
    input  wire logic [15:0] host_rdata
);
    initial begin
        host_strobe    = 1'b0;
        host_secondary = 1'b0;
        host_write     = 1'b0;
        host_addr      = 11'h000;
        host_wdata     = 16'h0000;
    end

    // One word access; ok stays low when no acknowledge comes
    task automatic access(input logic sec, input logic wr, input logic [10:0] a,
                          input logic [15:0] d, output logic [15:0] q, output logic ok);
        int n;
        n = 0;
        @(negedge mclk);
        host_secondary = sec;
        host_write = wr;
        host_addr = a;
        host_wdata = d;
        host_strobe = 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (host_ack !== 1'b1 && n < 12);
        ok = host_ack;
        q = host_rdata;
        @(negedge mclk);
        host_strobe = 1'b0;
        // Released lines must not look like a held request
        host_addr = ~a;
        host_wdata = ~d;
        host_write = ~wr;
        repeat (4) @(posedge mclk);
        n = 0;
        while (host_ack !== 1'b0 && n < 12) begin
            @(posedge mclk);
            n++;
        end
        // End on a falling edge so the caller's next drive stays off the sampling edge
        @(negedge mclk);
    endtask
endmodule // shm_host_bfm

//--- verif/shm_host_if_tb.sv
`timescale 1ns/1ps
`include "shm_regs.svh"

module shm_host_if_tb;
    logic        mclk, rst, ctl_wr, ctl_multi, diag_pass, fw_busy, fw_ready;
    logic        single_chan_card, host_strobe, host_secondary, host_write, host_ack;
    logic        ctl_reject, ctl_reset, qstart_evt, queue_started_flag, go_posted;
    logic        not_available_flag, board_good_flag, ok, exp_na, exp_bg;
    logic [2:0]  ctl_region;
    logic [7:0]  queue_len;
    logic [9:0]  ctl_addr;
    logic [10:0] host_addr, go_addr, last_go, a;
    logic [15:0] host_wdata, host_rdata, ctl_wdata, ctl_rdata, q, mcw;
    logic [15:0] mdl [0:1023];
    logic [10:0] bnd [16] = '{11'h000, 11'h00e, 11'h010, 11'h01a, 11'h01c, 11'h04a,
        11'h04c, 11'h72e, 11'h730, 11'h73e, 11'h740, 11'h762, 11'h764, 11'h7aa,
        11'h7ac, 11'h7fe};
    int          mismatches, n_checks, n_qs, n_go, rst_cnt, seed_dummy, n;

    shm_host_bfm host_u (.mclk(mclk), .host_strobe(host_strobe),
        .host_secondary(host_secondary), .host_write(host_write), .host_addr(host_addr),
        .host_wdata(host_wdata), .host_ack(host_ack), .host_rdata(host_rdata));

    shm_host_if dut_u (.mclk(mclk), .rst(rst), .host_strobe(host_strobe),
        .host_secondary(host_secondary), .host_write(host_write), .host_addr(host_addr),
        .host_wdata(host_wdata), .host_ack(host_ack), .host_rdata(host_rdata),
        .ctl_wr(ctl_wr), .ctl_multi(ctl_multi), .ctl_addr(ctl_addr), .ctl_wdata(ctl_wdata),
        .ctl_rdata(ctl_rdata), .ctl_region(ctl_region), .ctl_reject(ctl_reject),
        .diag_pass(diag_pass), .fw_busy(fw_busy), .fw_ready(fw_ready),
        .single_chan_card(single_chan_card), .queue_len(queue_len), .ctl_reset(ctl_reset),
        .qstart_evt(qstart_evt), .queue_started_flag(queue_started_flag),
        .go_posted(go_posted), .go_addr(go_addr), .not_available_flag(not_available_flag),
        .board_good_flag(board_good_flag));

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        if (qstart_evt === 1'b1) n_qs++;
        if (go_posted === 1'b1) begin
            n_go++;
            last_go = go_addr;
        end
        if (ctl_reset === 1'b1) rst_cnt++;
    end

    task automatic test_done();
        $display("checks=%0d mismatches=%0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chkb(input logic got, input logic exp);
        chk16({15'h0, got}, {15'h0, exp});
    endtask

    function automatic logic [2:0] region_of(input logic [10:0] b);
        if (b < 11'h010) return 3'h0;
        if (b < 11'h01c) return 3'h1;
        if (b < 11'h01c + 11'(12 * queue_len)) return 3'h2;
        if (b < 11'h730) return 3'h3;
        if (b < 11'h740) return 3'h4;
        if (b < 11'h764) return 3'h5;
        if (b < 11'h7ac) return 3'h6;
        return 3'h7;
    endfunction

    task automatic hwrite(input logic [10:0] ha, input logic [15:0] hd);
        host_u.access(1'b1, 1'b1, ha, hd, q, ok);
        chkb(ok, 1'b1);
        if (ha[10:1] == 10'h002) mcw = hd & 16'h3001;
        else if (ha >= 11'h010) mdl[ha[10:1]] = hd;
    endtask

    task automatic hread(input logic [10:0] ha);
        host_u.access(1'b1, 1'b0, ha, 16'h0000, q, ok);
        chkb(ok, 1'b1);
        chk16(q, ha[10:1] == 10'h000 ? {14'h0, exp_bg, exp_na} :
            ha[10:1] == 10'h002 ? mcw : ha < 11'h010 ? 16'h0000 : mdl[ha[10:1]]);
    endtask

    task automatic fw(input logic wr, input logic mu, input logic [9:0] wi,
                      input logic [15:0] wd);
        logic rej;
        rej = wi < 10'h008 || (wi >= 10'h3d6 && !(single_chan_card || mu));
        @(negedge mclk);
        ctl_wr = wr;
        ctl_multi = mu;
        ctl_addr = wi;
        ctl_wdata = wd;
        @(negedge mclk);
        ctl_wr = 1'b0;
        chk16({13'h0, ctl_region}, {13'h0, region_of({wi, 1'b0})});
        chkb(ctl_reject, wr & rej);
        @(negedge mclk);
        if (!wr) chk16(ctl_rdata, mdl[wi]);
        else if (!rej) mdl[wi] = wd;
    endtask

    task automatic ready_wait();
        @(negedge mclk);
        fw_ready = 1'b1;
        @(negedge mclk);
        fw_ready = 1'b0;
        n = 0;
        while ((board_good_flag !== 1'b1 || not_available_flag !== 1'b0) && n < 50) begin
            @(negedge mclk);
            n++;
        end
    endtask

    initial begin
        rst = 1'b1; ctl_wr = 1'b0; ctl_multi = 1'b0; ctl_addr = 10'h000;
        ctl_wdata = 16'h0000; diag_pass = 1'b0; fw_busy = 1'b0; fw_ready = 1'b0;
        single_chan_card = 1'b0; queue_len = 8'h04; mcw = 16'h0000;
        exp_na = 1'b1; exp_bg = 1'b0; mismatches = 0; n_checks = 0;
        n_qs = 0; n_go = 0; rst_cnt = 0;
        seed_dummy = $urandom(2);
        repeat (20) @(posedge mclk);
        @(negedge mclk);
        rst = 1'b0;
        chkb(not_available_flag, 1'b1);
        chkb(board_good_flag, 1'b0);
        hread(11'h004);
        hread(11'h000);
        diag_pass = 1'b1;
        ready_wait();
        exp_na = 1'b0;
        exp_bg = 1'b1;
        chkb(board_good_flag, 1'b1);
        hread(11'h000);
        fw_busy = 1'b1;
        repeat (3) @(negedge mclk);
        chkb(not_available_flag, 1'b1);
        fw_busy = 1'b0;
        // Control word: reserved bits dropped, start bit pulses once per 0->1
        hwrite(11'h004, 16'hefff);
        chk16(16'(n_qs), 16'h0001);
        chkb(queue_started_flag, 1'b1);
        hread(11'h004);
        hwrite(11'h004, 16'h0000);
        hwrite(11'h004, 16'h0001);
        chk16(16'(n_qs), 16'h0002);
        for (int i = 0; i < 8; i++) if (i != 2) begin
            hwrite(11'(2 * i), 16'($urandom));
            hread(11'(2 * i));
        end
        host_u.access(1'b0, 1'b1, 11'h004, 16'h0000, q, ok);
        chkb(ok, 1'b0);
        hread(11'h004);
        foreach (bnd[i]) fw(1'b1, 1'b0, bnd[i][10:1], 16'($urandom));
        foreach (bnd[i]) if (bnd[i] >= 11'h010 && bnd[i] < 11'h7ac) hread(bnd[i]);
        fw(1'b1, 1'b1, 10'h3ff, 16'($urandom));
        @(negedge mclk);
        single_chan_card = 1'b1;
        fw(1'b1, 1'b0, 10'h3d6, 16'($urandom));
        hread(11'h7fe);
        hread(11'h7ac);
        fw(1'b1, 1'b0, 10'h002, 16'hffff);
        hread(11'h004);
        repeat (6) begin
            a = {10'($urandom_range(128, 919)), 1'b0};
            hwrite(a, 16'($urandom));
            hread(a);
            fw(1'b0, 1'b0, a[10:1], 16'h0000);
        end
        // Command blocks above are in place before any go flag
        hwrite(11'h010, 16'h0001);
        chk16({5'h0, last_go}, 16'h0010);
        hwrite(11'h028, 16'h0001);
        chk16({5'h0, last_go}, 16'h0028);
        hwrite(11'h02a, 16'h0001);
        chk16(16'(n_go), 16'h0002);
        rst_cnt = 0;
        hwrite(11'h004, 16'h1001);
        exp_na = 1'b1;
        chkb(ctl_reset, 1'b1);
        chkb(not_available_flag, 1'b1);
        hread(11'h004);
        repeat (`SHM_RST_CYCLES) @(posedge mclk);
        hwrite(11'h004, 16'h0000);
        n = 0;
        while (ctl_reset !== 1'b0 && n < 50) begin
            @(negedge mclk);
            n++;
        end
        chkb(ctl_reset, 1'b0);
        chkb(rst_cnt >= `SHM_RST_CYCLES, 1'b1);
        chkb(queue_started_flag, 1'b0);
        chkb(not_available_flag, 1'b1);
        ready_wait();
        chkb(not_available_flag, 1'b0);
        test_done();
    end

    // Whole run needs about 3000 cycles
    initial begin
        repeat (20000) @(posedge mclk);
        mismatches++;
        test_done();
    end
endmodule // shm_host_if_tb
